// *** plc_regs.svh ***
`ifndef PLC_REGS_SVH
`define PLC_REGS_SVH

// cluster dimensions
`define PLC_N_CELLS        16
`define PLC_N_INPUTS       40
`define PLC_N_PTERMS       56
`define PLC_PT_LAST        6'h37

// register byte offsets
`define PLC_AND_BASE       12'h000
`define PLC_AND_END        12'h380
`define PLC_OR_BASE        12'h400
`define PLC_OR_END         12'h480
`define PLC_CELL_BASE      12'h600
`define PLC_CELL_END       12'h680
`define PLC_CTRL_OFS       12'h680
`define PLC_STAT_OUT_OFS   12'h700
`define PLC_STAT_PIN_OFS   12'h704

// cell word a fields
`define PLC_CA_MODE        0
`define PLC_CA_XOR         2
`define PLC_CA_INV         3
`define PLC_CA_CSRC        4
`define PLC_CA_GCLK        6
`define PLC_CA_CPOL        8
`define PLC_CA_BOTH        9
`define PLC_CA_CEEN        10
`define PLC_CA_SSRC        11
`define PLC_CA_RSRC        13
`define PLC_CA_OSRC        15
`define PLC_CA_INREG       18
`define PLC_CA_CEPT        24
`define PLC_CA_MASK        32'h3f07ffff

// cell word b fields
`define PLC_CB_XORPT       0
`define PLC_CB_CLKPT       6
`define PLC_CB_SETPT       12
`define PLC_CB_RSTPT       18
`define PLC_CB_OEPT        24
`define PLC_CB_MASK        32'h3fffffff

// cluster control word fields
`define PLC_CT_CLK         0
`define PLC_CT_SET         6
`define PLC_CT_RST         12
`define PLC_CT_OE          18
`define PLC_CT_MASK        32'h00ffffff

// and word 2 and or word 1 masks
`define PLC_AND2_MASK      32'h0000ffff
`define PLC_OR1_MASK       32'h00ffffff

// reset value of every configuration word
`define PLC_CFG_RST        32'h00000000

`endif

// *** plc_pkg.sv ***
`include "plc_regs.svh"
package plc_pkg;

   typedef enum logic [1:0] {
      plc_mode_comb  = 2'h0,
      plc_mode_dff   = 2'h1,
      plc_mode_tff   = 2'h2,
      plc_mode_latch = 2'h3
   } plc_mode_t;

   typedef enum logic [1:0] {
      plc_clk_global  = 2'h0,
      plc_clk_cluster = 2'h1,
      plc_clk_local   = 2'h2,
      plc_clk_none    = 2'h3
   } plc_clk_src_t;

   typedef enum logic [1:0] {
      plc_sr_none    = 2'h0,
      plc_sr_global  = 2'h1,
      plc_sr_cluster = 2'h2,
      plc_sr_local   = 2'h3
   } plc_sr_src_t;

   typedef enum logic [2:0] {
      plc_oe_off     = 3'h0,
      plc_oe_on      = 3'h1,
      plc_oe_global0 = 3'h2,
      plc_oe_global1 = 3'h3,
      plc_oe_cluster = 3'h4,
      plc_oe_local   = 3'h5
   } plc_oe_src_t;

   typedef logic [`PLC_N_PTERMS-1:0] plc_pt_vec_t;
   typedef logic [5:0]               plc_pt_idx_t;

   typedef struct packed {
      logic state;
      logic clk_prev;
      logic out;
      logic oe;
      logic pin_fb;
   } plc_cell_st_t;

   typedef struct packed {
      logic [`PLC_N_PTERMS-1:0][`PLC_N_INPUTS-1:0] and_t;
      logic [`PLC_N_PTERMS-1:0][`PLC_N_INPUTS-1:0] and_c;
      logic [`PLC_N_CELLS-1:0][`PLC_N_PTERMS-1:0]  or_m;
      logic [`PLC_N_CELLS-1:0][31:0]               cfg_a;
      logic [`PLC_N_CELLS-1:0][31:0]               cfg_b;
      logic [31:0]                                 ctrl;
      logic                                        pready;
      logic                                        pslverr;
      logic [31:0]                                 prdata;
   } plc_top_st_t;

   function automatic logic plc_pick(input plc_pt_vec_t pt, input plc_pt_idx_t idx);
      plc_pick = (idx <= `PLC_PT_LAST) ? pt[idx] : 1'b0;
   endfunction

endpackage

// *** plc_cell.sv ***
`timescale 1ns/100ps
`include "plc_regs.svh"
module plc_cell
   import plc_pkg::*;
(
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst,
   // array and configuration
   input  wire plc_pt_vec_t pterm,
   input  wire plc_pt_vec_t or_mask,
   input  wire logic [31:0] cfg_a,
   input  wire logic [31:0] cfg_b,
   // global and cluster controls
   input  wire logic [2:0]  global_clk,
   input  wire logic        global_set,
   input  wire logic        global_reset,
   input  wire logic [1:0]  global_oe,
   input  wire logic        cluster_clock_term,
   input  wire logic        cluster_async_set_term,
   input  wire logic        cluster_async_reset_term,
   input  wire logic        cluster_output_enable_term,
   // pin side
   input  wire logic        pin_in,
   output logic             cell_out,
   output logic             cell_oe,
   output logic             pin_feedback
);

   plc_cell_st_t st_r;
   plc_cell_st_t st_nxt;
   plc_mode_t    mode;
   logic         sop;
   logic         xr;
   logic         lv;
   logic         clk_raw;
   logic         clk_lvl;
   logic         edge_hit;
   logic         set_act;
   logic         rst_act;
   logic         d_in;
   logic         inreg;

   assign mode  = plc_mode_t'(cfg_a[`PLC_CA_MODE +: 2]);
   assign inreg = cfg_a[`PLC_CA_INREG];

   always_comb begin
      st_nxt = st_r;
      sop = |(pterm & or_mask);
      xr = cfg_a[`PLC_CA_XOR] ? (sop ^ plc_pick(pterm, cfg_b[`PLC_CB_XORPT +: 6])) : sop;
      lv = cfg_a[`PLC_CA_INV] ? ~xr : xr;
      case (plc_clk_src_t'(cfg_a[`PLC_CA_CSRC +: 2]))
         plc_clk_global: begin
            clk_raw = (cfg_a[`PLC_CA_GCLK +: 2] == 2'h3) ? 1'b0
                                                        : global_clk[cfg_a[`PLC_CA_GCLK +: 2]];
         end
         plc_clk_cluster: clk_raw = cluster_clock_term;
         plc_clk_local:   clk_raw = plc_pick(pterm, cfg_b[`PLC_CB_CLKPT +: 6]);
         default:         clk_raw = 1'b0;
      endcase
      clk_lvl = clk_raw ^ cfg_a[`PLC_CA_CPOL];
      case (plc_sr_src_t'(cfg_a[`PLC_CA_SSRC +: 2]))
         plc_sr_global:  set_act = global_set;
         plc_sr_cluster: set_act = cluster_async_set_term;
         plc_sr_local:   set_act = plc_pick(pterm, cfg_b[`PLC_CB_SETPT +: 6]);
         default:        set_act = 1'b0;
      endcase
      case (plc_sr_src_t'(cfg_a[`PLC_CA_RSRC +: 2]))
         plc_sr_global:  rst_act = global_reset;
         plc_sr_cluster: rst_act = cluster_async_reset_term;
         plc_sr_local:   rst_act = plc_pick(pterm, cfg_b[`PLC_CB_RSTPT +: 6]);
         default:        rst_act = 1'b0;
      endcase
      d_in = inreg ? pin_in : lv;
      edge_hit = cfg_a[`PLC_CA_BOTH] ? (clk_lvl ^ st_r.clk_prev)
                                     : (clk_lvl & ~st_r.clk_prev);
      st_nxt.clk_prev = clk_lvl;
      case (mode)
         plc_mode_dff: begin
            if (edge_hit && (!cfg_a[`PLC_CA_CEEN]
                             || plc_pick(pterm, cfg_a[`PLC_CA_CEPT +: 6]))) begin
               st_nxt.state = d_in;
            end
         end
         plc_mode_tff: begin
            if (edge_hit && d_in) begin
               st_nxt.state = ~st_r.state;
            end
         end
         plc_mode_latch: begin
            if (clk_lvl) begin
               st_nxt.state = d_in;
            end
         end
         default: st_nxt.state = st_r.state;
      endcase
      if (rst_act) begin
         st_nxt.state = 1'b0;
      end else if (set_act) begin
         st_nxt.state = 1'b1;
      end
      st_nxt.out = (mode == plc_mode_comb || inreg) ? lv : st_nxt.state;
      case (plc_oe_src_t'(cfg_a[`PLC_CA_OSRC +: 3]))
         plc_oe_on:      st_nxt.oe = 1'b1;
         plc_oe_global0: st_nxt.oe = global_oe[0];
         plc_oe_global1: st_nxt.oe = global_oe[1];
         plc_oe_cluster: st_nxt.oe = cluster_output_enable_term;
         plc_oe_local:   st_nxt.oe = plc_pick(pterm, cfg_b[`PLC_CB_OEPT +: 6]);
         default:        st_nxt.oe = 1'b0;
      endcase
      st_nxt.pin_fb = inreg ? st_nxt.state : pin_in;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign cell_out     = st_r.out;
   assign cell_oe      = st_r.oe;
   assign pin_feedback = st_r.pin_fb;

   a_reset_wins: assert property (@(posedge core_clk) disable iff (rst)
      rst_act |=> !st_r.state) else $error("reset did not clear cell state");
   a_set_forces: assert property (@(posedge core_clk) disable iff (rst)
      set_act && !rst_act |=> st_r.state) else $error("set did not force cell state");
   a_toggle_edge: assert property (@(posedge core_clk) disable iff (rst)
      mode == plc_mode_tff && !set_act && !rst_act && edge_hit && d_in
      |=> st_r.state != $past(st_r.state)) else $error("t mode failed to toggle");
   a_ce_hold: assert property (@(posedge core_clk) disable iff (rst)
      mode == plc_mode_dff && cfg_a[`PLC_CA_CEEN] && !set_act && !rst_act
      && !plc_pick(pterm, cfg_a[`PLC_CA_CEPT +: 6]) |=> $stable(st_r.state))
      else $error("d mode changed with enable low");
   a_comb_path: assert property (@(posedge core_clk) disable iff (rst)
      mode == plc_mode_comb && !inreg |=> st_r.out == $past(lv))
      else $error("combinational output mismatch");
   a_pin_return: assert property (@(posedge core_clk) disable iff (rst)
      !inreg |=> st_r.pin_fb == $past(pin_in)) else $error("pin feedback mismatch");
   c_toggle: cover property (@(posedge core_clk) disable iff (rst)
      mode == plc_mode_tff && edge_hit && d_in);
   c_both_edge: cover property (@(posedge core_clk) disable iff (rst)
      mode == plc_mode_dff && cfg_a[`PLC_CA_BOTH] && edge_hit && !clk_lvl);

endmodule

// *** plc_cluster.sv ***
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/100ps
`include "plc_regs.svh"
// What this block does
// - sixteen cells fed by forty routed inputs
// - fifty-six product terms shared across the cluster
// - any product term reaches any cell
// - one function may use all terms
// - one term feeds up to sixteen cells
// - sharing terms needs no common controls
// - optional xor with one extra term
// - selectable output polarity per cell
// - combinational, d, t or latch storage
// - clock, set, reset, oe source per cell
// - single or both edge capture
// - clock polarity selectable per cell
// - d mode clock enable holds state
// - cluster clock, set, reset, oe terms
// - storage can register its own pin
// - logic stays usable as buried node
// - selections come from static configuration
module plc_cluster
   import plc_pkg::*;
(
   // clock and reset
   input  wire logic                     core_clk,
   input  wire logic                     rst,
   // apb slave
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [11:0]              paddr,
   input  wire logic [31:0]              pwdata,
   output logic      [31:0]              prdata,
   output logic                          pready,
   output logic                          pslverr,
   // global routing matrix inputs
   input  wire logic [`PLC_N_INPUTS-1:0] route_in,
   // device wide controls
   input  wire logic [2:0]               global_clk,
   input  wire logic                     global_set,
   input  wire logic                     global_reset,
   input  wire logic [1:0]               global_oe,
   // io pins
   input  wire logic [`PLC_N_CELLS-1:0]  pin_in,
   output logic      [`PLC_N_CELLS-1:0]  pin_out,
   output logic      [`PLC_N_CELLS-1:0]  pin_oe,
   // returns to global routing matrix
   output logic      [`PLC_N_CELLS-1:0]  cell_feedback,
   output logic      [`PLC_N_CELLS-1:0]  pin_feedback
);

   plc_top_st_t                 st_r;
   plc_top_st_t                 st_nxt;
   plc_pt_vec_t                 pterm;
   logic                        cluster_clock_term;
   logic                        cluster_async_set_term;
   logic                        cluster_async_reset_term;
   logic                        cluster_output_enable_term;
   logic [`PLC_N_CELLS-1:0]     cell_q;
   logic [`PLC_N_CELLS-1:0]     cell_oe_q;
   logic [`PLC_N_CELLS-1:0]     pin_fb_q;
   logic                        acc;
   logic                        commit;
   logic                        and_hit;
   logic                        or_hit;
   logic                        cell_hit;
   logic                        ctrl_hit;
   logic                        stat_hit;
   logic                        hit;
   logic [5:0]                  pt_idx;
   logic [1:0]                  and_k;
   logic [3:0]                  cell_idx;
   logic [31:0]                 rdata;

   // bus and array checks below share this clock and reset
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   // product terms over true and complement literals
   always_comb begin
      for (int p = 0; p < `PLC_N_PTERMS; p++) begin
         pterm[p] = &(~st_r.and_t[p] | route_in) & &(~st_r.and_c[p] | ~route_in);
      end
   end

   // shared control terms picked from the array
   assign cluster_clock_term         = plc_pick(pterm, st_r.ctrl[`PLC_CT_CLK +: 6]);
   assign cluster_async_set_term     = plc_pick(pterm, st_r.ctrl[`PLC_CT_SET +: 6]);
   assign cluster_async_reset_term   = plc_pick(pterm, st_r.ctrl[`PLC_CT_RST +: 6]);
   assign cluster_output_enable_term = plc_pick(pterm, st_r.ctrl[`PLC_CT_OE +: 6]);

   // address decode
   always_comb begin
      pt_idx   = paddr[9:4];
      and_k    = paddr[3:2];
      cell_idx = paddr[6:3];
      and_hit  = (paddr < `PLC_AND_END) && (and_k != 2'h3);
      or_hit   = (paddr >= `PLC_OR_BASE) && (paddr < `PLC_OR_END);
      cell_hit = (paddr >= `PLC_CELL_BASE) && (paddr < `PLC_CELL_END);
      ctrl_hit = (paddr == `PLC_CTRL_OFS);
      stat_hit = (paddr == `PLC_STAT_OUT_OFS) || (paddr == `PLC_STAT_PIN_OFS);
      hit      = (paddr[1:0] == 2'h0) && (and_hit || or_hit || cell_hit || ctrl_hit
                 || (stat_hit && !pwrite));
      rdata    = 32'h00000000;
      if (and_hit) begin
         case (and_k)
            2'h0:    rdata = st_r.and_t[pt_idx][31:0];
            2'h1:    rdata = {st_r.and_c[pt_idx][23:0], st_r.and_t[pt_idx][39:32]};
            default: rdata = {16'h0000, st_r.and_c[pt_idx][39:24]};
         endcase
      end else if (or_hit) begin
         rdata = paddr[2] ? {8'h00, st_r.or_m[cell_idx][55:32]} : st_r.or_m[cell_idx][31:0];
      end else if (cell_hit) begin
         rdata = paddr[2] ? st_r.cfg_b[cell_idx] : st_r.cfg_a[cell_idx];
      end else if (ctrl_hit) begin
         rdata = st_r.ctrl;
      end else if (paddr == `PLC_STAT_OUT_OFS) begin
         rdata = {16'h0000, cell_q};
      end else if (paddr == `PLC_STAT_PIN_OFS) begin
         rdata = {16'h0000, pin_fb_q};
      end
   end

   assign acc    = psel && penable && !st_r.pready;
   assign commit = psel && penable && st_r.pready && pwrite && hit;

   // apb answer and configuration writes
   always_comb begin
      st_nxt         = st_r;
      st_nxt.pready  = 1'b0;
      st_nxt.pslverr = 1'b0;
      st_nxt.prdata  = 32'h00000000;
      if (acc) begin
         st_nxt.pready  = 1'b1;
         st_nxt.pslverr = !hit;
         st_nxt.prdata  = (pwrite || !hit) ? 32'h00000000 : rdata;
      end
      if (commit) begin
         if (and_hit) begin
            case (and_k)
               2'h0: st_nxt.and_t[pt_idx][31:0] = pwdata;
               2'h1: begin
                  st_nxt.and_t[pt_idx][39:32] = pwdata[7:0];
                  st_nxt.and_c[pt_idx][23:0]  = pwdata[31:8];
               end
               default: st_nxt.and_c[pt_idx][39:24] = pwdata[15:0];
            endcase
         end else if (or_hit) begin
            if (paddr[2]) begin
               st_nxt.or_m[cell_idx][55:32] = pwdata[23:0];
            end else begin
               st_nxt.or_m[cell_idx][31:0] = pwdata;
            end
         end else if (cell_hit) begin
            if (paddr[2]) begin
               st_nxt.cfg_b[cell_idx] = pwdata & `PLC_CB_MASK;
            end else begin
               st_nxt.cfg_a[cell_idx] = pwdata & `PLC_CA_MASK;
            end
         end else if (ctrl_hit) begin
            st_nxt.ctrl = pwdata & `PLC_CT_MASK;
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // sixteen identical cells
   genvar c;
   generate
      for (c = 0; c < `PLC_N_CELLS; c++) begin : g_cell
         plc_cell u_cell (
            .core_clk                   (core_clk),
            .rst                        (rst),
            .pterm                      (pterm),
            .or_mask                    (st_r.or_m[c]),
            .cfg_a                      (st_r.cfg_a[c]),
            .cfg_b                      (st_r.cfg_b[c]),
            .global_clk                 (global_clk),
            .global_set                 (global_set),
            .global_reset               (global_reset),
            .global_oe                  (global_oe),
            .cluster_clock_term         (cluster_clock_term),
            .cluster_async_set_term     (cluster_async_set_term),
            .cluster_async_reset_term   (cluster_async_reset_term),
            .cluster_output_enable_term (cluster_output_enable_term),
            .pin_in                     (pin_in[c]),
            .cell_out                   (cell_q[c]),
            .cell_oe                    (cell_oe_q[c]),
            .pin_feedback               (pin_fb_q[c])
         );

         a_cfg_masked: assert property (@(posedge core_clk) disable iff (rst)
            (st_r.cfg_a[c] & ~`PLC_CA_MASK) == 32'h00000000
            && (st_r.cfg_b[c] & ~`PLC_CB_MASK) == 32'h00000000)
            else $error("reserved configuration bits set");
      end
   endgenerate

   assign prdata        = st_r.prdata;
   assign pready        = st_r.pready;
   assign pslverr       = st_r.pslverr;
   assign pin_out       = cell_q;
   assign pin_oe        = cell_oe_q;
   assign cell_feedback = cell_q;
   assign pin_feedback  = pin_fb_q;

   a_ready_next: assert property (@(posedge core_clk) disable iff (rst)
      acc |=> pready ##1 !pready) else $error("apb answer not one cycle after access");
   a_unmapped_err: assert property (@(posedge core_clk) disable iff (rst)
      acc && !hit |=> pslverr && prdata == 32'h00000000) else $error("unmapped access no error");
   a_ctrl_write: assert property (@(posedge core_clk) disable iff (rst)
      commit && ctrl_hit |=> st_r.ctrl == ($past(pwdata) & `PLC_CT_MASK))
      else $error("control word write lost");
   a_cfg_static: assert property (@(posedge core_clk) disable iff (rst)
      !commit |=> $stable(st_r.cfg_a) && $stable(st_r.or_m))
      else $error("configuration changed without a write");
   a_stat_read: assert property (@(posedge core_clk) disable iff (rst)
      acc && !pwrite && paddr == `PLC_STAT_OUT_OFS |=> prdata[15:0] == $past(cell_q))
      else $error("status read does not show cell outputs");
   c_cfg_write: cover property (@(posedge core_clk) disable iff (rst) commit && cell_hit);
   c_err_resp: cover property (@(posedge core_clk) disable iff (rst) pready && pslverr);
   c_shared_term: cover property (@(posedge core_clk) disable iff (rst)
      (st_r.or_m[0] & st_r.or_m[1]) != '0 && cell_q[0] && cell_q[1]);

   // bus answer checks
   a_answer_pulse: assert property (
      pready |=> !pready)
      else $error("apb answer longer than one cycle");

   a_idle_quiet: assert property (
      !pready |-> prdata == 32'h00000000 && !pslverr)
      else $error("read data or error outside the answer");

   a_no_access: assert property (
      !(psel && penable) |=> !pready)
      else $error("answer without an access phase");

   a_read_ok: assert property (
      acc && hit |=> !pslverr)
      else $error("mapped access answered with error");

   a_write_silent: assert property (
      acc && pwrite |=> prdata == 32'h00000000)
      else $error("write answered with read data");

   a_ro_refused: assert property (
      acc && pwrite && stat_hit |=> pslverr)
      else $error("write to status word not refused");

   // read path checks
   a_ctrl_read: assert property (
      acc && !pwrite && ctrl_hit |=> prdata == $past(st_r.ctrl))
      else $error("control word read mismatch");

   a_pin_stat_read: assert property (
      acc && !pwrite && paddr == `PLC_STAT_PIN_OFS
      |=> prdata == {16'h0000, $past(pin_fb_q)})
      else $error("pin status read mismatch");

   a_cell_read: assert property (
      acc && hit && !pwrite && cell_hit && cell_idx == 4'h0 && !paddr[2]
      |=> prdata == $past(st_r.cfg_a[0]))
      else $error("cell word read mismatch");

   a_or_read: assert property (
      acc && hit && !pwrite && or_hit && cell_idx == 4'h3 && paddr[2]
      |=> prdata == {8'h00, $past(st_r.or_m[3][55:32])})
      else $error("or mask read mismatch");

   a_and_read: assert property (
      acc && hit && !pwrite && and_hit && pt_idx == 6'h02 && and_k == 2'h2
      |=> prdata == {16'h0000, $past(st_r.and_c[2][39:24])})
      else $error("and word read mismatch");

   // configuration and array checks
   a_array_static: assert property (
      !commit |=> $stable(st_r.cfg_b) && $stable(st_r.ctrl)
      && $stable(st_r.and_t) && $stable(st_r.and_c))
      else $error("array changed without a write");

   a_ctrl_reserved: assert property (
      st_r.ctrl[31:24] == 8'h00)
      else $error("reserved control bits set");

   a_term_select: assert property (
      st_r.ctrl[`PLC_CT_CLK +: 6] == `PLC_PT_LAST |-> cluster_clock_term == pterm[55])
      else $error("cluster clock term not the selected term");

   a_pterm_empty: assert property (
      (st_r.and_t[3] | st_r.and_c[3]) == '0 |-> pterm[3])
      else $error("empty product term not one");

   a_pterm_conflict: assert property (
      (st_r.and_t[2] & st_r.and_c[2]) != '0 |-> !pterm[2])
      else $error("contradicting product term not zero");

endmodule

// *** plc_pin_model.sv ***
`timescale 1ns/100ps
`include "plc_regs.svh"
module plc_pin_model (
   // pins from the cluster
   input  wire logic [`PLC_N_CELLS-1:0] pin_out,
   input  wire logic [`PLC_N_CELLS-1:0] pin_oe,
   // far side drive, a new pattern every cycle
   input  wire logic [`PLC_N_CELLS-1:0] ext_drv,
   // resolved pin level
   output logic      [`PLC_N_CELLS-1:0] pin_lvl
);
   // undriven pins never hold the last driven value
   assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_drv);
endmodule

// *** pla_logic_cluster_cell_tb_top.sv ***
`timescale 1ns/100ps
`include "plc_regs.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; \
   $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module pla_logic_cluster_cell_tb_top;
   logic        core_clk, rst, psel, penable, pwrite, pready, pslverr, er, chk_on;
   logic        global_set, global_reset, gp, lp, cp, t0, t1, t55, g;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [39:0] route_in;
   logic [2:0]  global_clk;
   logic [1:0]  global_oe;
   logic [15:0] pin_in, pin_out, pin_oe, cell_feedback, pin_feedback, ext_drv;
   logic [15:0] st, e_out, e_pfb, e_oe;
   int          errors, n_tests;
   // address and data of each configuration word
   localparam logic [43:0] CFG [22] = '{44'h000_00000001, 44'h010_00000002,
      44'h014_00000400, 44'h374_00000080, 44'h680_00000037, 44'h41c_00800000,
      44'h608_00000008, 44'h610_00000004, 44'h614_00000001, 44'h620_00000001,
      44'h628_00000002, 44'h630_00000201, 44'h638_00000101, 44'h640_00002801,
      44'h648_01000401, 44'h650_00000003, 44'h658_00040001, 44'h660_00008000,
      44'h668_00010000, 44'h670_00000021, 44'h674_00000040, 44'h678_00000011};
   // refused accesses: direction and address
   localparam logic [12:0] BAD [4] = '{13'h0800, 13'h1700, 13'h0002, 13'h000c};

   plc_cluster DUT (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .route_in(route_in), .global_clk(global_clk),
      .global_set(global_set), .global_reset(global_reset), .global_oe(global_oe),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .cell_feedback(cell_feedback), .pin_feedback(pin_feedback));
   plc_pin_model PIN (.pin_out(pin_out), .pin_oe(pin_oe), .ext_drv(ext_drv),
      .pin_lvl(pin_in));

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   task finish_test;
      $display("errors %0d comparisons %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      if (n >= 20) errors++;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // cycle model of the configured cells, compared at every edge once chk_on is set
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st = '0;
         gp = 1'b0;
         lp = 1'b0;
         cp = 1'b0;
      end else begin
         if (chk_on) begin
            `CHK(cell_feedback[3:0], e_out[3:0])
            `CHK(cell_feedback[11:4], e_out[11:4])
            `CHK(cell_feedback[15:12], e_out[15:12])
            `CHK(pin_out, e_out)
            `CHK(pin_feedback, e_pfb)
            `CHK(pin_oe, e_oe)
         end
         t0 = route_in[0];
         t1 = route_in[1] & ~route_in[2];
         t55 = route_in[39];
         g = global_clk[0];
         if (g & ~gp) st[4] = t0;
         if (g & ~gp & t0) st[5] = ~st[5];
         if (g != gp) st[6] = t0;
         if (~g & gp) st[7] = t0;
         if (global_reset) st[8] = 1'b0;
         else if (global_set) st[8] = 1'b1;
         else if (g & ~gp) st[8] = t0;
         if (g & ~gp & t1) st[9] = t0;
         if (g) st[10] = t0;
         if (g & ~gp) st[11] = pin_in[11];
         if (t1 & ~lp) st[14] = t0;
         if (t55 & ~cp) st[15] = t0;
         gp = g;
         lp = t1;
         cp = t55;
         e_out = {st[15:14], {3{t0}}, st[10:4], t0 | t55, t0 ^ t1, ~t0, t0};
         e_pfb = pin_in;
         e_pfb[11] = st[11];
         e_oe = {2'h0, global_oe[0], 1'b1, 12'h000};
      end
   end

   initial begin
      {psel, penable, pwrite, paddr, pwdata, route_in, global_clk} = '0;
      {global_set, global_reset, global_oe, ext_drv, chk_on} = '0;
      errors = 0;
      n_tests = 0;
      rst = 1'b1;
      void'($urandom(80));
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      apb(1'b0, 12'h600, 32'h0);
      `CHK({er, rd}, {1'b0, `PLC_CFG_RST})
      foreach (BAD[i]) begin
         apb(BAD[i][12], BAD[i][11:0], 32'h1);
         `CHK({er, rd}, 33'h100000000)
      end
      apb(1'b1, 12'h028, 32'hffffffff);
      apb(1'b0, 12'h028, 32'h0);
      `CHK({er, rd}, {1'b0, `PLC_AND2_MASK})
      apb(1'b1, 12'h024, 32'h00000080);
      foreach (CFG[i]) apb(1'b1, CFG[i][43:32], CFG[i][31:0]);
      for (int c = 0; c < 16; c++) apb(1'b1, 12'h400 + 12'(c * 8), 32'h1);
      apb(1'b0, 12'h41c, 32'h0);
      `CHK(rd, 32'h00800000)
      repeat (2) @(posedge core_clk);
      chk_on <= 1'b1;
      repeat (3000) begin
         @(posedge core_clk);
         route_in <= {8'($urandom), 32'($urandom)};
         global_clk <= 3'($urandom);
         global_set <= ($urandom % 8) == 0;
         global_reset <= ($urandom % 8) == 0;
         global_oe <= 2'($urandom);
         ext_drv <= 16'($urandom);
      end
      repeat (3) @(posedge core_clk);
      apb(1'b0, 12'h700, 32'h0);
      `CHK(rd, {16'h0000, e_out})
      finish_test;
   end

   initial begin
      #200000;
      errors++;
      finish_test;
   end
endmodule
